//--- verilog/high_side_switch_control.sv
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module high_side_switch_control (
    input wire logic clk,
    input wire logic reset,
    input wire hs_switch_pkg::sbc_mode_t sbcMode,
    input wire hs_switch_pkg::sense_t sense,
    output logic [3:0] switchOutput,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef struct packed {
        logic awRdy;
        logic bValid;
        logic [1:0] bResp;
        logic arRdy;
        logic rValid;
        logic [1:0] rResp;
        logic [31:0] rData;
        logic [3:0][2:0] cfg;
        logic ovDis;
        logic uvDis;
        logic rec;
        logic [1:0][7:0] duty;
        logic [1:0] rate;
        logic [3:0] ocFlag;
        logic [3:0] olFlag;
        logic supOv;
        logic supUv;
        hs_switch_pkg::sense_t sync1;
        hs_switch_pkg::sense_t sync2;
        logic [1:0][9:0] pre;
        logic [1:0][7:0] phase;
        logic [3:0][11:0] ocCnt;
        logic [3:0][11:0] olCnt;
        logic [3:0] out;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    hs_switch_pkg::sense_t s;
    logic ovFault;
    logic uvFault;
    logic fault;
    logic halt;
    logic lowPower;
    logic wrEn;
    logic [7:0] wAddr;
    logic [1:0] pwm;

    assign s = st_r.sync2;
    assign ovFault = s.ov && !st_r.ovDis;
    assign uvFault = s.uv && !st_r.uvDis;
    assign fault = ovFault || uvFault;
    assign halt = sbcMode == hs_switch_pkg::MODE_HALT;
    assign lowPower = sbcMode == hs_switch_pkg::MODE_STOP || sbcMode == hs_switch_pkg::MODE_SLEEP;
    assign wrEn = st_r.awRdy && s_axi_awvalid && s_axi_wvalid;
    assign wAddr = s_axi_awaddr[7:0];
    assign pwm[0] = st_r.phase[0] < st_r.duty[0];
    assign pwm[1] = st_r.phase[1] < st_r.duty[1];

    always_comb
    begin
        logic want;
        logic lock;
        want = 1'b0;
        lock = lowPower || halt;
        st_nxt = st_r;
        st_nxt.sync1 = sense;
        st_nxt.sync2 = st_r.sync1;
        // Raw supply levels only, no other flag touched
        st_nxt.supOv = s.ov;
        st_nxt.supUv = s.uv;

        // Generators run free; 200 or 400 Hz per generator
        for (int g = 0; g < 2; g++)
        begin
            // At or past the limit, so a rate change never stretches a step
            if (st_r.pre[g] >= (st_r.rate[g] ? hs_switch_pkg::PRE_FAST
                : hs_switch_pkg::PRE_SLOW) - 10'h001)
            begin
                st_nxt.pre[g] = 10'h000;
                st_nxt.phase[g] = st_r.phase[g] + 8'h01;
            end
            else
            begin
                st_nxt.pre[g] = st_r.pre[g] + 10'h001;
            end
        end

        // Write channel
        st_nxt.awRdy = !st_r.awRdy && !st_r.bValid && s_axi_awvalid && s_axi_wvalid;
        if (st_r.bValid && s_axi_bready)
        begin
            st_nxt.bValid = 1'b0;
        end
        if (wrEn)
        begin
            st_nxt.bValid = 1'b1;
            st_nxt.bResp = hs_switch_pkg::RESP_OKAY;
            if (!s_axi_wstrb[0])
            begin
                st_nxt.bResp = hs_switch_pkg::RESP_OKAY;
            end
            else if (wAddr == hs_switch_pkg::ADDR_CFG_A)
            begin
                if (!lock) st_nxt.cfg[1:0] = {s_axi_wdata[6:4], s_axi_wdata[2:0]};
            end
            else if (wAddr == hs_switch_pkg::ADDR_CFG_B)
            begin
                if (!lock) st_nxt.cfg[3:2] = {s_axi_wdata[6:4], s_axi_wdata[2:0]};
            end
            else if (wAddr == hs_switch_pkg::ADDR_SUPPLY_CTRL)
            begin
                if (!lock)
                begin
                    st_nxt.ovDis = s_axi_wdata[hs_switch_pkg::CTRL_OV_DIS];
                    st_nxt.uvDis = s_axi_wdata[hs_switch_pkg::CTRL_UV_DIS];
                    st_nxt.rec = s_axi_wdata[hs_switch_pkg::CTRL_REC];
                end
            end
            else if (wAddr == hs_switch_pkg::ADDR_DUTY_ONE)
            begin
                if (!lock) st_nxt.duty[0] = s_axi_wdata[7:0];
            end
            else if (wAddr == hs_switch_pkg::ADDR_DUTY_TWO)
            begin
                if (!lock) st_nxt.duty[1] = s_axi_wdata[7:0];
            end
            else if (wAddr == hs_switch_pkg::ADDR_RATE)
            begin
                if (!lock) st_nxt.rate = s_axi_wdata[1:0];
            end
            else if (wAddr == hs_switch_pkg::ADDR_OC_STAT)
            begin
                st_nxt.ocFlag = st_r.ocFlag & ~s_axi_wdata[3:0];
            end
            else if (wAddr == hs_switch_pkg::ADDR_OL_STAT)
            begin
                st_nxt.olFlag = st_r.olFlag & ~s_axi_wdata[3:0];
            end
            else if (wAddr != hs_switch_pkg::ADDR_SUPPLY_STAT)
            begin
                st_nxt.bResp = hs_switch_pkg::RESP_SLVERR;
            end
        end

        // Read channel
        st_nxt.arRdy = !st_r.arRdy && !st_r.rValid && s_axi_arvalid;
        if (st_r.rValid && s_axi_rready)
        begin
            st_nxt.rValid = 1'b0;
        end
        if (st_r.arRdy && s_axi_arvalid)
        begin
            st_nxt.rValid = 1'b1;
            st_nxt.rResp = hs_switch_pkg::RESP_OKAY;
            st_nxt.rData = 32'h0000_0000;
            if (s_axi_araddr[7:0] == hs_switch_pkg::ADDR_CFG_A)
                st_nxt.rData[6:0] = {st_r.cfg[1], 1'b0, st_r.cfg[0]};
            else if (s_axi_araddr[7:0] == hs_switch_pkg::ADDR_CFG_B)
                st_nxt.rData[6:0] = {st_r.cfg[3], 1'b0, st_r.cfg[2]};
            else if (s_axi_araddr[7:0] == hs_switch_pkg::ADDR_SUPPLY_CTRL)
                st_nxt.rData[2:0] = {st_r.rec, st_r.uvDis, st_r.ovDis};
            else if (s_axi_araddr[7:0] == hs_switch_pkg::ADDR_DUTY_ONE)
                st_nxt.rData[7:0] = st_r.duty[0];
            else if (s_axi_araddr[7:0] == hs_switch_pkg::ADDR_DUTY_TWO)
                st_nxt.rData[7:0] = st_r.duty[1];
            else if (s_axi_araddr[7:0] == hs_switch_pkg::ADDR_RATE)
                st_nxt.rData[1:0] = st_r.rate;
            else if (s_axi_araddr[7:0] == hs_switch_pkg::ADDR_OC_STAT)
                st_nxt.rData[3:0] = st_r.ocFlag;
            else if (s_axi_araddr[7:0] == hs_switch_pkg::ADDR_OL_STAT)
                st_nxt.rData[3:0] = st_r.olFlag;
            else if (s_axi_araddr[7:0] == hs_switch_pkg::ADDR_SUPPLY_STAT)
                st_nxt.rData[1:0] = {st_r.supUv, st_r.supOv};
            else
                st_nxt.rResp = hs_switch_pkg::RESP_SLVERR;
        end

        // Supply fault without recovery drops configuration
        if (fault && !st_r.rec)
        begin
            st_nxt.cfg = '0;
        end
        if (halt)
        begin
            st_nxt.cfg = '0;
        end

        // Switch drive and protection, active in every mode except halt
        for (int i = 0; i < 4; i++)
        begin
            case (st_r.cfg[i])
                hs_switch_pkg::CFG_ON: want = 1'b1;
                hs_switch_pkg::CFG_T1: want = s.timer[0];
                hs_switch_pkg::CFG_T2: want = s.timer[1];
                hs_switch_pkg::CFG_P1: want = pwm[0];
                hs_switch_pkg::CFG_P2: want = pwm[1];
                default: want = 1'b0;
            endcase
            // Held off while faulted; returns when fault clears if recovery kept the configuration
            st_nxt.out[i] = want && !fault && !halt;

            if (st_r.out[i] && s.overCur[i])
                st_nxt.ocCnt[i] = st_r.ocCnt[i] + 12'h001;
            else
                st_nxt.ocCnt[i] = 12'h000;
            if (st_r.out[i] && s.overCur[i] && st_r.ocCnt[i] == hs_switch_pkg::OC_CYC - 12'h001)
            begin
                st_nxt.ocFlag[i] = 1'b1;
                st_nxt.cfg[i] = hs_switch_pkg::CFG_OFF;
                st_nxt.out[i] = 1'b0;
                st_nxt.ocCnt[i] = 12'h000;
            end

            if (st_r.out[i] && s.lowCur[i])
                st_nxt.olCnt[i] = st_r.olCnt[i] + 12'h001;
            else
                st_nxt.olCnt[i] = 12'h000;
            if (st_r.out[i] && s.lowCur[i] && st_r.olCnt[i] == hs_switch_pkg::OL_CYC - 12'h001)
            begin
                st_nxt.olFlag[i] = 1'b1;
                st_nxt.olCnt[i] = 12'h000;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign switchOutput = st_r.out;
    assign s_axi_awready = st_r.awRdy;
    assign s_axi_wready = st_r.awRdy;
    assign s_axi_bvalid = st_r.bValid;
    assign s_axi_bresp = st_r.bResp;
    assign s_axi_arready = st_r.arRdy;
    assign s_axi_rvalid = st_r.rValid;
    assign s_axi_rresp = st_r.rResp;
    assign s_axi_rdata = st_r.rData;

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    a_supply_off: assert property (fault |=> st_r.out == 4'h0)
        else $error("output on during supply fault");
    a_uv_disable: assert property (s.uv && !s.ov && st_r.uvDis && !halt
        && st_r.cfg[0] == hs_switch_pkg::CFG_ON && !s.overCur[0] |=> st_r.out[0])
        else $error("undervoltage shutoff not disabled");
    a_norec_clear: assert property (fault && !st_r.rec |=> st_r.cfg == '0)
        else $error("configuration kept without recovery");
    a_oc_filter: assert property ($rose(st_r.ocFlag[0]) |-> $past(st_r.ocCnt[0])
        == hs_switch_pkg::OC_CYC - 12'h001 && st_r.cfg[0] == 3'h0 && !st_r.out[0])
        else $error("overcurrent shutoff timing wrong");
    a_oc_sticky: assert property (st_r.ocFlag[0]
        && !(wrEn && wAddr == hs_switch_pkg::ADDR_OC_STAT) |=> st_r.ocFlag[0])
        else $error("overcurrent flag lost");
    a_ol_filter: assert property ($rose(st_r.olFlag[0]) |-> $past(st_r.out[0])
        && $past(st_r.olCnt[0]) == hs_switch_pkg::OL_CYC - 12'h001)
        else $error("open load flagged wrongly");
    a_lp_lock: assert property (lowPower && wrEn |=> $stable(st_r.duty)
        && $stable(st_r.rate) && $stable(st_r.rec)
        && (st_r.cfg & ~$past(st_r.cfg)) == 12'h000)
        else $error("configuration changed in low power");
    a_halt_off: assert property (halt |=> st_r.out == 4'h0 && st_r.cfg == '0)
        else $error("outputs live in restart");
    a_pwm_follow: assert property (st_r.cfg[1] == hs_switch_pkg::CFG_P2 && !fault
        && !halt && !s.overCur[1] |=> st_r.out[1] == $past(pwm[1]))
        else $error("generator not driving output");
endmodule
`default_nettype wire

//--- shared/hs_switch_pkg.sv
// Function
// - Output source: direct bit, timer or generator
// - Overvoltage switches on outputs off, then resumes
// - Undervoltage switches outputs off, then resumes
// - Overvoltage and undervoltage shutoff separately disableable
// - Recovery bit set: restore programmed configuration
// - Recovery clear: stay off, clear configuration
// - Supply faults only in supply flags
// - Overcurrent beyond filter time switches off
// - Overcurrent sets flag, clears configuration
// - Overcurrent flag cleared only by software
// - Open load checked when on; stays on
// - Open-load flags sticky until software clears
// - Configuration locked in stop and sleep
// - Restart or fail-safe disables all outputs
// - Protections stay active in low power
// - Two generators, 8-bit duty each
// - Each generator selects 200 or 400 Hz
// - Generator output starts on assignment
// - Any output assignable to any source
// - Open-load filter 64 us
package hs_switch_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int OC_FILTER_NS = 16000;
    localparam int OL_FILTER_NS = 64000;
    localparam logic [11:0] OC_CYC = 12'((OC_FILTER_NS * (CLK_HZ / 1_000_000)) / 1000);
    localparam logic [11:0] OL_CYC = 12'((OL_FILTER_NS * (CLK_HZ / 1_000_000)) / 1000);
    localparam int PWM_SLOW_HZ = 200;
    localparam int PWM_FAST_HZ = 400;
    localparam logic [9:0] PRE_SLOW = 10'(CLK_HZ / (PWM_SLOW_HZ * 256));
    localparam logic [9:0] PRE_FAST = 10'(CLK_HZ / (PWM_FAST_HZ * 256));

    localparam logic [7:0] ADDR_CFG_A = 8'h00;
    localparam logic [7:0] ADDR_CFG_B = 8'h04;
    localparam logic [7:0] ADDR_SUPPLY_CTRL = 8'h08;
    localparam logic [7:0] ADDR_DUTY_ONE = 8'h0C;
    localparam logic [7:0] ADDR_DUTY_TWO = 8'h10;
    localparam logic [7:0] ADDR_RATE = 8'h14;
    localparam logic [7:0] ADDR_OC_STAT = 8'h18;
    localparam logic [7:0] ADDR_OL_STAT = 8'h1C;
    localparam logic [7:0] ADDR_SUPPLY_STAT = 8'h20;

    localparam int CTRL_OV_DIS = 0;
    localparam int CTRL_UV_DIS = 1;
    localparam int CTRL_REC = 2;

    localparam logic [2:0] CFG_OFF = 3'h0;
    localparam logic [2:0] CFG_ON = 3'h1;
    localparam logic [2:0] CFG_T1 = 3'h2;
    localparam logic [2:0] CFG_T2 = 3'h3;
    localparam logic [2:0] CFG_P1 = 3'h4;
    localparam logic [2:0] CFG_P2 = 3'h5;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        MODE_NORMAL = 4'h1,
        MODE_STOP = 4'h2,
        MODE_SLEEP = 4'h4,
        MODE_HALT = 4'h8
    } sbc_mode_t;

    typedef struct packed {
        logic ov;
        logic uv;
        logic [3:0] overCur;
        logic [3:0] lowCur;
        logic [1:0] timer;
    } sense_t;
endpackage

//--- bench/load_model.sv
`timescale 1ns/1ps
`default_nettype none
module load_model (
    input wire logic [3:0] switchOutput,
    input wire logic [3:0] shortMask,
    input wire logic [3:0] openMask,
    output logic [3:0] overCur,
    output logic [3:0] lowCur
);
    // A switch that is off carries no current
    assign overCur = switchOutput & shortMask;
    assign lowCur = ~switchOutput | openMask;
endmodule
`default_nettype wire

//--- bench/high_side_switch_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module high_side_switch_control_tb_top;
    logic clk = 1'b0;
    logic reset = 1'b1;
    hs_switch_pkg::sbc_mode_t sbcMode = hs_switch_pkg::MODE_NORMAL;
    hs_switch_pkg::sense_t sense;
    logic ov = 1'b0, uv = 1'b0;
    logic [1:0] tmr = 2'h0;
    logic [3:0] shortMask = 4'h0, openMask = 4'h0;
    logic [3:0] overCur, lowCur, switchOutput;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rd;
    int bad_count = 0, checked = 0;

    always #12.5 clk = ~clk;
    assign sense = {ov, uv, overCur, lowCur, tmr};

    load_model load_model_inst (.switchOutput, .shortMask, .openMask, .overCur, .lowCur);
    high_side_switch_control high_side_switch_control_inst (.clk, .reset, .sbcMode,
        .sense, .switchOutput, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: exp %h got %h", $time, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Waits to a settled high answer; the next rising edge completes it
    task automatic hold(ref logic s);
        int i;
        i = 0;
        do
        begin
            @(negedge clk);
            i++;
        end while (s !== 1'b1 && i < 200);
        if (s !== 1'b1)
        begin
            bad_count++;
            tally_and_finish;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        s_axi_awaddr <= {24'h00_0000, a};
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        hold(s_axi_awready);
        @(posedge clk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        hold(s_axi_bvalid);
        rsp = s_axi_bresp;
        @(posedge clk);
    endtask

    task automatic rdw(input logic [7:0] a);
        s_axi_araddr <= {24'h00_0000, a};
        s_axi_arvalid <= 1'b1;
        hold(s_axi_arready);
        @(posedge clk);
        s_axi_arvalid <= 1'b0;
        hold(s_axi_rvalid);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        @(posedge clk);
    endtask

    task automatic t_sources;
        rdw(8'h40);
        chk(32'(hs_switch_pkg::RESP_SLVERR), 32'(rsp));
        wr(hs_switch_pkg::ADDR_CFG_A, 8'h01);
        wr(hs_switch_pkg::ADDR_CFG_B, 8'h30);
        tmr <= 2'h2;
        cyc(6);
        chk(32'h0000_0009, 32'(switchOutput));
        tmr <= 2'h0;
        cyc(6);
        chk(32'h0000_0001, 32'(switchOutput));
        $display("sources done");
    endtask

    task automatic t_supply;
        wr(hs_switch_pkg::ADDR_SUPPLY_CTRL, 8'h04);
        ov <= 1'b1;
        cyc(6);
        chk(32'h0, 32'(switchOutput[0]));
        rdw(hs_switch_pkg::ADDR_SUPPLY_STAT);
        chk(32'h0000_0001, rd);
        rdw(hs_switch_pkg::ADDR_OC_STAT);
        chk(32'h0, rd);
        ov <= 1'b0;
        cyc(6);
        chk(32'h0000_0001, 32'(switchOutput[0]));
        wr(hs_switch_pkg::ADDR_SUPPLY_CTRL, 8'h00);
        uv <= 1'b1;
        cyc(6);
        chk(32'h0, 32'(switchOutput[0]));
        uv <= 1'b0;
        cyc(6);
        chk(32'h0, 32'(switchOutput[0]));
        rdw(hs_switch_pkg::ADDR_CFG_A);
        chk(32'h0, rd);
        wr(hs_switch_pkg::ADDR_SUPPLY_CTRL, 8'h01);
        wr(hs_switch_pkg::ADDR_CFG_A, 8'h01);
        ov <= 1'b1;
        cyc(6);
        chk(32'h0000_0001, 32'(switchOutput[0]));
        ov <= 1'b0;
        cyc(4);
        wr(hs_switch_pkg::ADDR_SUPPLY_CTRL, 8'h02);
        uv <= 1'b1;
        cyc(6);
        chk(32'h0000_0001, 32'(switchOutput[0]));
        uv <= 1'b0;
        $display("supply done");
    endtask

    task automatic t_faults;
        shortMask <= 4'h1;
        cyc(600);
        chk(32'h0000_0001, 32'(switchOutput[0]));
        cyc(60);
        chk(32'h0, 32'(switchOutput[0]));
        shortMask <= 4'h0;
        rdw(hs_switch_pkg::ADDR_CFG_A);
        chk(32'h0, rd);
        wr(hs_switch_pkg::ADDR_CFG_A, 8'h01);
        cyc(4);
        rdw(hs_switch_pkg::ADDR_OC_STAT);
        chk(32'h0000_0001, rd);
        wr(hs_switch_pkg::ADDR_OC_STAT, 8'h01);
        rdw(hs_switch_pkg::ADDR_OC_STAT);
        chk(32'h0, rd);
        openMask <= 4'h1;
        cyc(2400);
        rdw(hs_switch_pkg::ADDR_OL_STAT);
        chk(32'h0, rd);
        cyc(200);
        rdw(hs_switch_pkg::ADDR_OL_STAT);
        chk(32'h0000_0001, rd);
        chk(32'h0000_0001, 32'(switchOutput[0]));
        openMask <= 4'h0;
        cyc(10);
        rdw(hs_switch_pkg::ADDR_OL_STAT);
        chk(32'h0000_0001, rd);
        wr(hs_switch_pkg::ADDR_OL_STAT, 8'h01);
        rdw(hs_switch_pkg::ADDR_OL_STAT);
        chk(32'h0, rd);
        $display("faults done");
    endtask

    task automatic t_modes;
        sbcMode <= hs_switch_pkg::MODE_STOP;
        wr(hs_switch_pkg::ADDR_CFG_A, 8'h02);
        rdw(hs_switch_pkg::ADDR_CFG_A);
        chk(32'h0000_0001, rd);
        shortMask <= 4'h1;
        cyc(700);
        chk(32'h0, 32'(switchOutput[0]));
        shortMask <= 4'h0;
        sbcMode <= hs_switch_pkg::MODE_NORMAL;
        wr(hs_switch_pkg::ADDR_OC_STAT, 8'h01);
        wr(hs_switch_pkg::ADDR_CFG_A, 8'h01);
        sbcMode <= hs_switch_pkg::MODE_HALT;
        cyc(4);
        chk(32'h0, 32'(switchOutput[0]));
        sbcMode <= hs_switch_pkg::MODE_NORMAL;
        wr(hs_switch_pkg::ADDR_CFG_A, 8'h01);
        cyc(4);
        chk(32'h0000_0001, 32'(switchOutput[0]));
        $display("modes done");
    endtask

    task automatic t_pwm;
        int i, n, n2;
        n = 0;
        n2 = 0;
        // Both generators run in step at one rate, so their falls differ by the duties
        wr(hs_switch_pkg::ADDR_DUTY_ONE, 8'h20);
        wr(hs_switch_pkg::ADDR_DUTY_TWO, 8'h28);
        wr(hs_switch_pkg::ADDR_RATE, 8'h03);
        wr(hs_switch_pkg::ADDR_CFG_A, 8'h54);
        cyc(4);
        @(negedge clk);
        for (i = 0; i < 20000 && switchOutput[0]; i++)
            @(negedge clk);
        if (switchOutput[0])
        begin
            bad_count++;
            tally_and_finish;
        end
        for (i = 0; i < 4000 && switchOutput[1]; i++)
        begin
            n++;
            n2 += int'(switchOutput[0]);
            @(negedge clk);
        end
        if (switchOutput[1])
        begin
            bad_count++;
            tally_and_finish;
        end
        chk(32'(hs_switch_pkg::PRE_FAST) * 32'h0000_0008, 32'(n));
        chk(32'h0, 32'(n2));
        $display("pwm done");
    endtask

    initial
    begin
        cyc(10);
        reset <= 1'b0;
        cyc(2);
        t_sources();
        t_supply();
        t_faults();
        t_modes();
        t_pwm();
        tally_and_finish();
    end
endmodule
`default_nettype wire
